// *** inc/scan_params.svh ***
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CORE_CLK_HZ        250000000
`define TRIG_MIN_PULSE_MS  10
`define TRIG_SPACING_MS    100
`define TRIG_LOCKOUT_MS    50
`define FRAME_MARK_US      100
`define STEP_RATE_HZ       60
`define MOD_WL1_HZ         4000
`define MOD_WL2_HZ         5000
`define BLINK_HZ           2

`define TRIG_LOCKOUT_CYC   (`CORE_CLK_HZ / 1000 * `TRIG_LOCKOUT_MS)
`define FRAME_MARK_CYC     (`CORE_CLK_HZ / 1000000 * `FRAME_MARK_US)
`define STEP_CYC           (`CORE_CLK_HZ / `STEP_RATE_HZ)
`define MOD_WL1_HALF_CYC   (`CORE_CLK_HZ / (2 * `MOD_WL1_HZ))
`define MOD_WL2_HALF_CYC   (`CORE_CLK_HZ / (2 * `MOD_WL2_HZ))
`define BLINK_HALF_CYC     (`CORE_CLK_HZ / (2 * `BLINK_HZ))

// ----------------------------------------------------------------------
// Sizes, gain control and demodulation
// ----------------------------------------------------------------------
`define NUM_TRIG           4
`define MAX_SOURCES        16
`define GROUP_SOURCES      8
`define MAX_CHANNELS       16
`define CH_PER_MODULE      4
`define MAX_MODULES        3'h4
`define SAMPLE_BITS        16
`define GAIN_BITS          2
`define GAIN_RESET         2'h1
`define GAIN_MAX           2'h3
`define GAIN_HI_LEVEL      16'h7000
`define GAIN_LO_LEVEL      16'h0800
`define DEMOD_SHIFT        8
`define FIFO_DEPTH         32

`endif

// *** inc/scan_pkg.sv ***
// ----------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------
package scan_pkg;

  typedef logic [15:0][15:0] adc_bus_t;
  typedef logic [15:0][1:0]  gain_bus_t;

  typedef struct packed {
    logic [7:0]  frame;
    logic [3:0]  source;
    logic [3:0]  channel;
    logic        wavelength;
    logic [3:0]  events;
    logic [1:0]  gain;
    logic [15:0] value;
  } sample_word_t;

  typedef enum logic [0:0] {
    SER_IDLE,
    SER_SEND
  } ser_state_t;

endpackage

// *** logic/sample_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge core_clk_in) begin
    if (in_valid_in && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid_in && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** logic/optical_scan_trigger_timing.sv ***
// Summary of operation
// RULE1: Four trigger inputs each record an event only on a rising edge.
// RULE2: The trigger source holds every pulse high for at least 10 ms.
// RULE3: Pulses 100 ms apart are separate events, with no length limit.
// RULE4: Each frame start gives one 0.1 ms high pulse on the frame marker.
// RULE5: Sources are switched on one at a time in turn at about 60 Hz.
// RULE6: Both wavelengths run at once on own tones and are demodulated.
// RULE7: Each channel picks its gain from the received light level.
// RULE8: Each filtered detector output is taken as a 16-bit sample.
// RULE9: Status light is steady on attach and blinks once the link is up.
// RULE10: Ready only while status blinks and the power light is lit.
// RULE11: All detector channels are read in parallel, four per module.
// RULE12: Channel count is set from 4 to 16 in steps of one four-channel module.
// RULE13: Sources 1 to 8 go to group A and 9 to 16 to group B.
// RULE14: Trigger events are stamped into the sample stream they meet.
// RULE15: Each trigger passes a two-stage synchronizer before edge checks.
// RULE16: After an accepted edge an input ignores edges for a lockout.
`timescale 1ns/1ps
`default_nettype none
`include "scan_params.svh"

module optical_scan_trigger_timing
  import scan_pkg::*;
#(
  parameter int unsigned LOCKOUT_CYC = `TRIG_LOCKOUT_CYC,
  parameter int unsigned MARK_CYC    = `FRAME_MARK_CYC,
  parameter int unsigned STEP_CYC    = `STEP_CYC,
  parameter int unsigned MOD1_CYC    = `MOD_WL1_HALF_CYC,
  parameter int unsigned MOD2_CYC    = `MOD_WL2_HALF_CYC,
  parameter int unsigned BLINK_CYC   = `BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // Event triggers
  input  wire logic [3:0]  trig_in,
  // Scan configuration
  input  wire logic        scan_enable_in,
  input  wire logic [4:0]  src_count_in,
  input  wire logic [2:0]  det_modules_in,
  // Detector samples
  input  wire logic        adc_valid_in,
  input  wire adc_bus_t    adc_data_in,
  // Host link and power
  input  wire logic        host_attach_in,
  input  wire logic        link_up_in,
  input  wire logic        power_good_in,
  // Source drive
  output logic [7:0]       led_grp_a_out,
  output logic [7:0]       led_grp_b_out,
  output logic             mod_wl1_out,
  output logic             mod_wl2_out,
  output gain_bus_t        gain_sel_out,
  output logic             frame_mark_out,
  // Indicators
  output logic             status_led_out,
  output logic             power_led_out,
  output logic             ready_out,
  // Sample stream
  output logic             stream_valid_out,
  input  wire logic        stream_ready_in,
  output sample_word_t     stream_data_out,
  output logic             overrun_out
);

  // --------------------------------------------------------------------
  // Trigger inputs
  // --------------------------------------------------------------------
  logic [3:0] trig_meta;
  logic [3:0] trig_sync;
  logic [3:0] trig_last;
  logic [3:0] trig_hit;
  logic [3:0] ev_pend;
  logic       ev_take;

  // RULE15: two-stage sync.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      trig_meta <= 4'h0;
      trig_sync <= 4'h0;
      trig_last <= 4'h0;
    end else begin
      trig_meta <= trig_in;
      trig_sync <= trig_meta;
      trig_last <= trig_sync;
    end
  end

  // The lockout stays well under the pulse spacing, so a legal train of
  // pulses is never merged, while contact bounce after an edge is eaten.
  for (genvar t = 0; t < `NUM_TRIG; t++) begin : g_trig
    logic [31:0] lock_cnt;
    // RULE1: rising edge only.
    // RULE16: lockout gates edges.
    assign trig_hit[t] = trig_sync[t] && !trig_last[t] &&
                         (lock_cnt == 32'h0);
    // RULE3: lockout below spacing.
    always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
        lock_cnt <= 32'h0;
      end else if (trig_hit[t]) begin
        lock_cnt <= LOCKOUT_CYC;
      end else if (lock_cnt != 32'h0) begin
        lock_cnt <= lock_cnt - 32'h1;
      end
    end
  end

  // RULE14: events held until stamped.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ev_pend <= 4'h0;
    end else begin
      ev_pend <= (ev_take ? 4'h0 : ev_pend) | trig_hit;
    end
  end

  // --------------------------------------------------------------------
  // Status indicators
  // --------------------------------------------------------------------
  logic [31:0] blink_cnt;
  logic        blink;
  logic        scan_run;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !link_up_in) begin
      blink_cnt <= 32'h0;
      blink     <= 1'b1;
    end else if (blink_cnt >= BLINK_CYC - 1) begin
      blink_cnt <= 32'h0;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  // RULE9: steady, then blinking.
  // RULE10: ready needs both lights.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      status_led_out <= 1'b0;
      power_led_out  <= 1'b0;
      ready_out      <= 1'b0;
    end else begin
      status_led_out <= host_attach_in && (!link_up_in || blink);
      power_led_out  <= power_good_in;
      ready_out      <= host_attach_in && link_up_in && power_good_in;
    end
  end

  assign scan_run = scan_enable_in && ready_out;

  // --------------------------------------------------------------------
  // Source stepping and frame marker
  // --------------------------------------------------------------------
  logic [31:0] step_cnt;
  logic [31:0] mark_cnt;
  logic [3:0]  src_idx;
  logic [3:0]  src_last;
  logic [7:0]  frame_num;
  logic        step_end;
  logic        run_last;
  logic        frame_start;
  logic [15:0] src_onehot;

  assign src_last = (src_count_in == 5'h0) ? 4'h0 :
                    (src_count_in > 5'h10) ? 4'hf :
                    4'(src_count_in - 5'h1);
  assign step_end = scan_run && (step_cnt >= STEP_CYC - 1);
  assign frame_start = scan_run &&
                       (!run_last || (step_end && src_idx >= src_last));

  // RULE5: one source per step.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !scan_run) begin
      step_cnt <= 32'h0;
    end else if (step_end) begin
      step_cnt <= 32'h0;
    end else begin
      step_cnt <= step_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      run_last  <= 1'b0;
      src_idx   <= 4'h0;
      frame_num <= 8'h0;
    end else begin
      run_last <= scan_run;
      if (frame_start) begin
        src_idx   <= 4'h0;
        frame_num <= frame_num + 8'h1;
      end else if (step_end) begin
        src_idx <= src_idx + 4'h1;
      end
    end
  end

  // RULE4: fixed-length marker.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mark_cnt       <= 32'h0;
      frame_mark_out <= 1'b0;
    end else if (frame_start) begin
      mark_cnt       <= MARK_CYC - 1;
      frame_mark_out <= 1'b1;
    end else if (mark_cnt != 32'h0) begin
      mark_cnt <= mark_cnt - 32'h1;
    end else begin
      frame_mark_out <= 1'b0;
    end
  end

  assign src_onehot = 16'h1 << src_idx;

  // RULE13: split into two groups.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !run_last || !scan_run || frame_start) begin
      led_grp_a_out <= 8'h0;
      led_grp_b_out <= 8'h0;
    end else begin
      led_grp_a_out <= src_onehot[7:0];
      led_grp_b_out <= src_onehot[15:8];
    end
  end

  // --------------------------------------------------------------------
  // Wavelength modulation
  // --------------------------------------------------------------------
  logic [31:0] mod1_cnt;
  logic [31:0] mod2_cnt;

  // RULE6: two distinct tones.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !scan_run) begin
      mod1_cnt    <= 32'h0;
      mod2_cnt    <= 32'h0;
      mod_wl1_out <= 1'b0;
      mod_wl2_out <= 1'b0;
    end else begin
      mod1_cnt <= (mod1_cnt >= MOD1_CYC - 1) ? 32'h0 : mod1_cnt + 32'h1;
      mod2_cnt <= (mod2_cnt >= MOD2_CYC - 1) ? 32'h0 : mod2_cnt + 32'h1;
      if (mod1_cnt >= MOD1_CYC - 1) begin
        mod_wl1_out <= !mod_wl1_out;
      end
      if (mod2_cnt >= MOD2_CYC - 1) begin
        mod_wl2_out <= !mod_wl2_out;
      end
    end
  end

  // --------------------------------------------------------------------
  // Detector channels
  // --------------------------------------------------------------------
  logic signed [31:0] acc1 [`MAX_CHANNELS];
  logic signed [31:0] acc2 [`MAX_CHANNELS];
  logic [15:0]        peak [`MAX_CHANNELS];
  logic [15:0]        hold1 [`MAX_CHANNELS];
  logic [15:0]        hold2 [`MAX_CHANNELS];
  logic [1:0]         hold_gain [`MAX_CHANNELS];
  logic [2:0]         modules;
  logic [4:0]         ch_count;
  logic               snap;

  // RULE12: clamp module count.
  assign modules  = (det_modules_in == 3'h0) ? 3'h1 :
                    (det_modules_in > `MAX_MODULES) ? `MAX_MODULES :
                    det_modules_in;
  assign ch_count = {modules, 2'h0};

  // Each channel is a lock-in: the sample is added while its tone is high
  // and taken away while low, so the other tone averages out over a step.
  // RULE11: all channels at once.
  always_ff @(posedge core_clk_in) begin
    for (int c = 0; c < `MAX_CHANNELS; c++) begin
      logic signed [31:0] s;
      logic [15:0]        mag;
      // RULE8: 16-bit samples.
      s   = 32'(signed'(adc_data_in[c]));
      mag = adc_data_in[c][15] ? 16'(16'h0 - adc_data_in[c])
                               : adc_data_in[c];
      if (!resetn_in || step_end || !scan_run) begin
        acc1[c] <= 32'sh0;
        acc2[c] <= 32'sh0;
        peak[c] <= 16'h0;
      end else if (adc_valid_in) begin
        // RULE6: demodulate each tone.
        acc1[c] <= mod_wl1_out ? acc1[c] + s : acc1[c] - s;
        acc2[c] <= mod_wl2_out ? acc2[c] + s : acc2[c] - s;
        if (mag > peak[c]) begin
          peak[c] <= mag;
        end
      end
    end
  end

  // RULE7: step gain by peak level.
  always_ff @(posedge core_clk_in) begin
    for (int c = 0; c < `MAX_CHANNELS; c++) begin
      if (!resetn_in) begin
        gain_sel_out[c] <= `GAIN_RESET;
      end else if (step_end) begin
        if (peak[c] > `GAIN_HI_LEVEL && gain_sel_out[c] != 2'h0) begin
          gain_sel_out[c] <= gain_sel_out[c] - 2'h1;
        end else if (peak[c] < `GAIN_LO_LEVEL &&
                     gain_sel_out[c] != `GAIN_MAX) begin
          gain_sel_out[c] <= gain_sel_out[c] + 2'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Step snapshot and serializer
  // --------------------------------------------------------------------
  ser_state_t   ser_state;
  logic [4:0]   ser_idx;
  logic [4:0]   ser_ch_count;
  logic [3:0]   hold_src;
  logic [7:0]   hold_frame;
  logic [3:0]   hold_ev;
  logic         push_ready;
  logic         push_valid;
  sample_word_t push_word;

  // A step that ends before the last one is drained is dropped whole and
  // flagged, because overwriting a half-sent snapshot would mix steps.
  assign snap    = step_end && (ser_state == SER_IDLE);
  assign ev_take = snap;

  always_ff @(posedge core_clk_in) begin
    if (snap) begin
      for (int c = 0; c < `MAX_CHANNELS; c++) begin
        hold1[c]     <= 16'(acc1[c] >>> `DEMOD_SHIFT);
        hold2[c]     <= 16'(acc2[c] >>> `DEMOD_SHIFT);
        hold_gain[c] <= gain_sel_out[c];
      end
    end
  end

  // RULE14: events stamp the step.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      hold_src     <= 4'h0;
      hold_frame   <= 8'h0;
      hold_ev      <= 4'h0;
      ser_ch_count <= 5'h4;
    end else if (snap) begin
      hold_src     <= src_idx;
      hold_frame   <= frame_num;
      hold_ev      <= ev_pend;
      ser_ch_count <= ch_count;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ser_state <= SER_IDLE;
      ser_idx   <= 5'h0;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          ser_idx <= 5'h0;
          if (snap) begin
            ser_state <= SER_SEND;
          end
        end
        SER_SEND: begin
          if (push_ready) begin
            if (ser_idx[4:1] == 4'(ser_ch_count - 5'h1) && ser_idx[0]) begin
              ser_state <= SER_IDLE;
            end
            ser_idx <= ser_idx + 5'h1;
          end
        end
        default: begin
          ser_state <= SER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      overrun_out <= 1'b0;
    end else if (step_end && ser_state != SER_IDLE) begin
      overrun_out <= 1'b1;
    end
  end

  assign push_valid           = (ser_state == SER_SEND);
  assign push_word.frame      = hold_frame;
  assign push_word.source     = hold_src;
  assign push_word.channel    = ser_idx[4:1];
  assign push_word.wavelength = ser_idx[0];
  assign push_word.events     = hold_ev;
  assign push_word.gain       = hold_gain[ser_idx[4:1]];
  assign push_word.value      = ser_idx[0] ? hold2[ser_idx[4:1]]
                                           : hold1[ser_idx[4:1]];

  sample_fifo #(
    .WIDTH ($bits(sample_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (stream_valid_out),
    .out_ready_in  (stream_ready_in),
    .out_data_out  (stream_data_out)
  );

endmodule

`default_nettype wire

// *** bench/trig_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Trigger equipment model
// ------------------------------------------------------------
module trig_source_model #(
  parameter int MIN_HIGH = 4,
  parameter int MIN_GAP  = 250
) (
  // Clock
  input  wire logic        core_clk_in,
  // Requests from the bench
  input  wire logic [3:0]  fire_in,
  input  wire logic        bounce_in,
  input  wire logic [15:0] width_in,
  // Trigger pins
  output logic [3:0]       trig_out
);
  logic [15:0] high_cnt [4] = '{default: 16'h0};
  logic [15:0] gap_cnt  [4] = '{default: 16'h0};
  logic [3:0]  chatter      = 4'h0;

  always @(posedge core_clk_in) begin
    for (int t = 0; t < 4; t++) begin
      if (high_cnt[t] != 16'h0) high_cnt[t] <= high_cnt[t] - 16'h1;
      if (gap_cnt[t] != 16'h0) gap_cnt[t] <= gap_cnt[t] - 16'h1;
      if (fire_in[t] && gap_cnt[t] == 16'h0) begin
        high_cnt[t] <= (width_in < 16'(MIN_HIGH)) ? 16'(MIN_HIGH) : width_in;
        gap_cnt[t]  <= 16'(MIN_GAP);
        chatter[t]  <= bounce_in;
      end
    end
  end

  // Chatter mode cuts a short gap into the pulse to mimic a bouncing
  // contact; only the lockout scenario asks for it.
  always_comb begin
    for (int t = 0; t < 4; t++) begin
      trig_out[t] = high_cnt[t] != 16'h0 &&
                    !(chatter[t] && high_cnt[t] > 16'h3 && high_cnt[t] < 16'h7);
    end
  end
endmodule
`default_nettype wire

// *** bench/optical_scan_trigger_timing_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module scan_checker #(
  parameter int unsigned MARK_CYC  = 5,
  parameter int unsigned STEP_CYC  = 200,
  parameter int unsigned MOD1_CYC  = 3,
  parameter int unsigned BLINK_CYC = 10
) (
  // Clock, reset and inputs
  input wire logic       core_clk_in,
  input wire logic       resetn_in,
  input wire logic       scan_enable_in,
  input wire logic       host_attach_in,
  input wire logic       link_up_in,
  // Outputs
  input wire logic [7:0] led_grp_a_out,
  input wire logic [7:0] led_grp_b_out,
  input wire logic       mod_wl1_out,
  input wire logic       frame_mark_out,
  input wire logic       status_led_out,
  input wire logic       power_led_out,
  input wire logic       ready_out
);
  logic [15:0] leds;
  logic [15:0] prev_leds;
  logic        tone_prev;
  logic        status_prev;
  logic [31:0] mark_run, led_run, tone_run, blink_run;

  assign leds = {led_grp_b_out, led_grp_a_out};
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // Run lengths give exact widths without long repetitions.
  always_ff @(posedge core_clk_in) begin
    prev_leds   <= leds;
    tone_prev   <= mod_wl1_out;
    status_prev <= status_led_out;
    mark_run  <= (!resetn_in || !frame_mark_out) ? 32'h0 : mark_run + 32'h1;
    led_run   <= (!resetn_in || leds != prev_leds) ? 32'h1 : led_run + 32'h1;
    tone_run  <= (!resetn_in || mod_wl1_out != tone_prev) ? 32'h1 :
                 tone_run + 32'h1;
    blink_run <= (!resetn_in || !ready_out || status_led_out != status_prev) ?
                 32'h1 : blink_run + 32'h1;
  end

  a_mark_width: assert property (
    $fell(frame_mark_out) |-> mark_run == MARK_CYC) else $error("marker width");
  a_mark_start: assert property (
    $rose(scan_enable_in && ready_out) |=> frame_mark_out && leds == 16'h0)
    else $error("no marker at scan start");
  a_one_source: assert property (
    $onehot0(leds)) else $error("more than one source lit");
  a_scan_off: assert property (
    !scan_enable_in |=> leds == 16'h0) else $error("source lit while idle");
  a_step_len: assert property (
    leds != 16'h0 && $past(leds) > 16'h1 && leds != $past(leds) |->
    led_run == STEP_CYC) else $error("step length wrong");
  a_tone_half: assert property (
    leds != 16'h0 && led_run > 32'h8 && mod_wl1_out != tone_prev |->
    tone_run == MOD1_CYC) else $error("tone half period wrong");
  a_status_steady: assert property (
    host_attach_in && !link_up_in |=> status_led_out)
    else $error("status not steady");
  a_blink_live: assert property (
    ready_out |-> blink_run <= BLINK_CYC + 1) else $error("status not blinking");
  a_ready_power: assert property (
    ready_out |-> power_led_out && $past(link_up_in))
    else $error("ready without power");

  c_frame: cover property ($rose(frame_mark_out));
  c_step: cover property (leds != 16'h0 && $past(leds) > 16'h1 && $changed(leds));
  c_blink: cover property (ready_out && status_led_out != status_prev);
endmodule

bind optical_scan_trigger_timing scan_checker #(.MARK_CYC(MARK_CYC),
  .STEP_CYC(STEP_CYC), .MOD1_CYC(MOD1_CYC), .BLINK_CYC(BLINK_CYC)) chk (
  .core_clk_in, .resetn_in, .scan_enable_in, .host_attach_in, .link_up_in,
  .led_grp_a_out, .led_grp_b_out, .mod_wl1_out, .frame_mark_out,
  .status_led_out, .power_led_out, .ready_out);
`default_nettype wire

// *** bench/test_optical_scan_trigger_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch at %0t got %0h expected %0h", $time, (g), (e)); end end
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module test_optical_scan_trigger_timing
  import scan_pkg::*;
;
  logic         core_clk_in = 1'b0, resetn_in = 1'b0, scan_enable_in = 1'b0;
  logic [4:0]   src_count_in   = 5'h10;
  logic [2:0]   det_modules_in = 3'h1;
  logic         adc_valid_in = 1'b0, stream_ready_in = 1'b0;
  adc_bus_t     adc_data_in  = '0;
  logic         host_attach_in = 1'b0, link_up_in = 1'b0, power_good_in = 1'b0;
  logic [7:0]   led_grp_a_out, led_grp_b_out;
  logic         mod_wl1_out, mod_wl2_out, frame_mark_out, status_led_out;
  logic         power_led_out, ready_out, stream_valid_out, overrun_out;
  gain_bus_t    gain_sel_out;
  sample_word_t stream_data_out, w;
  logic [3:0]   trig, step_ev, fire_mask = 4'h0, src_idx = 4'h0;
  logic [15:0]  pulse_width = 16'h0, last_leds = 16'h0, cur;
  logic [31:0]  seed = 32'hea74;
  logic [5:0]   k = 6'h0;
  logic         bounce = 1'b0, stall = 1'b0, fast = 1'b0, big = 1'b0;
  logic         mark_last = 1'b0, prev_status;
  int           error_cnt = 0, checked = 0, led_idx = 0, mark_len = 0;
  int           nsrc = 16, mods = 1, n, toggles;
  int           ev_cnt [4] = '{default: 0};

  optical_scan_trigger_timing #(.LOCKOUT_CYC(20), .MARK_CYC(5),
    .STEP_CYC(200), .MOD1_CYC(3), .BLINK_CYC(10)) dut (
    .core_clk_in, .resetn_in, .trig_in(trig), .scan_enable_in, .src_count_in,
    .det_modules_in, .adc_valid_in, .adc_data_in, .host_attach_in,
    .link_up_in, .power_good_in, .led_grp_a_out, .led_grp_b_out, .mod_wl1_out,
    .mod_wl2_out, .gain_sel_out, .frame_mark_out, .status_led_out,
    .power_led_out, .ready_out, .stream_valid_out, .stream_ready_in,
    .stream_data_out, .overrun_out);
  trig_source_model host (.core_clk_in,
    .fire_in(fire_mask), .bounce_in(bounce), .width_in(pulse_width),
    .trig_out(trig));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_led(input int i);
    return 16'h1 << i;
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk_in);
    #1;
  endtask
  task automatic fire(input logic [3:0] m, input logic [15:0] wd);
    fire_mask = m;
    pulse_width = wd;
    tick(1);
    fire_mask = 4'h0;
    tick(1);
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  // Random samples and a random sink stall, 1 ns after each edge.
  always @(posedge core_clk_in) begin
    #1;
    seed = lfsr_next(seed);
    adc_valid_in = seed[3];
    stream_ready_in = !stall && (seed[5] || seed[6] || fast);
    for (int c = 0; c < 16; c++) begin
      adc_data_in[c] = big ? (seed[c] ? 16'h8100 : 16'h7800) :
                       {6'h0, seed[c +: 10]};
    end
  end
  // Sink: every accepted word is checked against the scan order.
  always @(posedge core_clk_in) begin
    if (resetn_in && stream_valid_out && stream_ready_in) begin
      w = stream_data_out;
      `CHK(w.wavelength, k[0])
      `CHK(w.channel, k[4:1])
      if (k == 6'h0) begin
        `CHK(w.source, src_idx)
        step_ev = w.events;
        for (int t = 0; t < 4; t++) ev_cnt[t] += int'(w.events[t]);
      end
      `CHK(w.events, step_ev)
      k = (int'(k) == 8 * mods - 1) ? 6'h0 : k + 6'h1;
      if (k == 6'h0) src_idx = 4'((int'(src_idx) + 1) % nsrc);
    end
  end
  always @(negedge core_clk_in) begin
    cur = {led_grp_b_out, led_grp_a_out};
    if (cur != last_leds && cur != 16'h0) begin
      `CHK(cur, exp_led(led_idx))
      led_idx = (led_idx + 1) % nsrc;
    end
    if (frame_mark_out && !mark_last) `CHK(led_idx, 0)
    mark_len = frame_mark_out ? mark_len + 1 : mark_len;
    if (!frame_mark_out && mark_last) `CHK(mark_len, 5)
    mark_len = frame_mark_out ? mark_len : 0;
    mark_last = frame_mark_out;
    last_leds = cur;
  end

  initial begin
    tick(20);
    resetn_in = 1'b1;
    tick(2);
    `CHK(status_led_out, 1'b0)
    host_attach_in = 1'b1;
    tick(2);
    for (n = 0; n < 20; n++) begin
      `CHK(status_led_out, 1'b1)
      tick(1);
    end
    link_up_in = 1'b1;
    toggles = 0;
    for (n = 0; n < 30; n++) begin
      prev_status = status_led_out;
      tick(1);
      toggles += int'(status_led_out !== prev_status);
    end
    `CHK(toggles > 1, 1'b1)
    `CHK(ready_out, 1'b0)
    power_good_in = 1'b1;
    tick(2);
    `CHK(ready_out, 1'b1)
    scan_enable_in = 1'b1;
    tick(300);
    fire(4'h1, 16'd6);
    fire(4'h2, 16'd6);
    fire(4'h4, 16'd300);
    tick(300);
    fire(4'h2, 16'd6);
    toggles = led_idx;
    for (n = 0; n < 400 && led_idx == toggles; n++) tick(1);
    `CHK(n < 400, 1'b1)
    // Two edges six cycles apart, straddling a step boundary.
    tick(194);
    bounce = 1'b1;
    fire(4'h8, 16'd9);
    bounce = 1'b0;
    tick(3200);
    for (n = 0; n < 4; n++) `CHK(gain_sel_out[n], 2'h3)
    `CHK(ev_cnt[0], 1)
    `CHK(ev_cnt[1], 2)
    `CHK(ev_cnt[2], 1)
    `CHK(ev_cnt[3], 1)
    scan_enable_in = 1'b0;
    fast = 1'b1;
    tick(100);
    nsrc = 3;
    mods = 4;
    src_count_in = 5'h03;
    det_modules_in = 3'h4;
    big = 1'b1;
    k = 6'h0;
    src_idx = 4'h0;
    led_idx = 0;
    scan_enable_in = 1'b1;
    for (n = 0; n < 400 && stream_valid_out !== 1'b1; n++) tick(1);
    stall = 1'b1;
    tick(60);
    `CHK(stream_valid_out, 1'b1)
    stall = 1'b0;
    tick(1500);
    for (n = 0; n < 16; n++) `CHK(gain_sel_out[n], 2'h0)
    `CHK(overrun_out, 1'b0)
    tally_and_finish();
  end
  // About 6000 cycles are expected; twice that means a hang.
  initial begin
    #48000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`undef CHK
`default_nettype wire
